// file: rtl/iim_monitor.sv
// isochronous interval monitor for one pipe, with a classic Wishbone register slave
// assumes link event inputs are single-cycle strobes from logic on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "iim_params.svh"
module iim_monitor #(
    parameter bit          HAS_INTERVAL = 1'b1,
    parameter int unsigned FRAME_CYCLES = `IIM_FRAME_NS / `IIM_CLK_NS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // link events
    input  wire logic        sof_i,
    input  wire logic        bus_reset_i,
    input  wire logic        in_token_ok_i,
    input  wire logic        in_token_err_i,
    input  wire logic        out_data_ok_i,
    input  wire logic        out_data_err_i,
    input  wire logic        out_fifo_full_i,
    input  wire logic        xact_active_i,
    // results
    output logic             frame_tick_o,
    output logic             not_ready_event_o,
    output logic             flush_o,
    output logic             flush_one_side_o
);
    localparam int TW = $clog2(FRAME_CYCLES + 1);

    typedef struct packed {
        logic                    ack;
        logic [31:0]             rdata;
        logic                    iso_in_flush_enable;
        logic [2:0]              interval_exponent;
        iim_pkg::iim_resp_t      response_select;
        logic                    auto_clear_mode;
        logic                    pipe_in_use;
        logic                    iso_type;
        logic                    dir_in;
        logic                    double_buffer_select;
        iim_pkg::iim_state_t     st;
        logic [`IIM_CNT_W-1:0]   cnt;
        logic                    seen;
        logic [TW-1:0]           tmr;
        logic                    not_ready_event;
        logic                    flush;
        logic                    side;
    } iim_regs_t;

    iim_regs_t s_reg;
    iim_regs_t s_next;

    // byte-lane merge, used for every writable register
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [`IIM_CNT_W-1:0] period_mask(input logic [2:0] e);
        logic [`IIM_CNT_W:0] one;
        one = {{`IIM_CNT_W{1'b0}}, 1'b1};
        return `IIM_CNT_W'((one << e) - one);
    endfunction

    logic        interp_tick;
    logic        frame_tick;
    logic        wr_stb;
    logic        good_pkt;
    logic        bad_pkt;
    logic        check_now;
    logic [2:0]  exp_eff;
    logic [31:0] tim_v;
    logic [31:0] ctl_v;
    logic [31:0] cfg_v;
    logic [31:0] sta_v;
    logic [31:0] wv;

    always_comb begin
        s_next = s_reg;
        wv     = 32'h0;
        // interpolate a frame strobe when the SOF is missing or corrupted
        interp_tick = !sof_i && (s_reg.tmr == TW'(FRAME_CYCLES - 1));
        frame_tick  = sof_i || interp_tick;
        s_next.tmr  = frame_tick ? '0 : s_reg.tmr + TW'(1);

        // a pipe without the field behaves as exponent zero
        exp_eff  = HAS_INTERVAL ? s_reg.interval_exponent : `IIM_EXP_RST;
        good_pkt = s_reg.dir_in ? in_token_ok_i : out_data_ok_i;
        // errors and a full buffer never count as a received packet
        bad_pkt  = s_reg.dir_in ? in_token_err_i : (out_data_err_i || out_fifo_full_i);

        // pipe in use follows the bus transaction
        s_next.pipe_in_use = xact_active_i;

        tim_v = 32'h0;
        tim_v[`IIM_TIM_FLUSH] = s_reg.iso_in_flush_enable;
        tim_v[`IIM_TIM_EXP_MSB:`IIM_TIM_EXP_LSB] = s_reg.interval_exponent;
        ctl_v = 32'h0;
        ctl_v[`IIM_CTL_RESP_MSB:`IIM_CTL_RESP_LSB] = s_reg.response_select;
        ctl_v[`IIM_CTL_BUSY] = s_reg.pipe_in_use;
        ctl_v[`IIM_CTL_ACLR] = s_reg.auto_clear_mode;
        cfg_v = 32'h0;
        cfg_v[`IIM_CFG_ISO]    = s_reg.iso_type;
        cfg_v[`IIM_CFG_DIR_IN] = s_reg.dir_in;
        cfg_v[`IIM_CFG_DBL]    = s_reg.double_buffer_select;
        sta_v = 32'h0;
        sta_v[`IIM_STA_CNT_MSB:`IIM_STA_CNT_LSB] = s_reg.cnt;
        sta_v[`IIM_STA_ST_MSB:`IIM_STA_ST_LSB]   = s_reg.st;
        sta_v[`IIM_STA_SEEN] = s_reg.seen;

        // single-wait-state slave: ack one cycle after the request, write at the ack edge
        s_next.ack = cyc_i && stb_i && !s_reg.ack;
        wr_stb     = cyc_i && stb_i && we_i && s_reg.ack;
        if (adr_i == `IIM_ADR_TIMING) begin
            s_next.rdata = tim_v;
        end else if (adr_i == `IIM_ADR_CONTROL) begin
            s_next.rdata = ctl_v;
        end else if (adr_i == `IIM_ADR_CONFIG) begin
            s_next.rdata = cfg_v;
        end else if (adr_i == `IIM_ADR_STATUS) begin
            s_next.rdata = sta_v;
        end else begin
            s_next.rdata = 32'h0;
        end

        // interval sequencing; events pulse for one cycle
        s_next.not_ready_event  = 1'b0;
        s_next.flush = 1'b0;
        check_now    = 1'b0;
        if (good_pkt) begin
            s_next.seen = 1'b1;
        end
        case (s_reg.st)
            iim_pkg::IIM_ST_IDLE: begin
                if (s_reg.response_select == iim_pkg::IIM_RESP_BUF && s_reg.iso_type) begin
                    s_next.st = iim_pkg::IIM_ST_ARMED;
                end
            end
            iim_pkg::IIM_ST_ARMED: begin
                // exponent zero starts with the next frame
                if (exp_eff == 3'h0 && frame_tick) begin
                    s_next.st   = iim_pkg::IIM_ST_RUN;
                    s_next.cnt  = '0;
                    s_next.seen = 1'b0;
                // otherwise the first good packet opens the first interval
                end else if (exp_eff != 3'h0 && good_pkt) begin
                    s_next.st   = iim_pkg::IIM_ST_RUN;
                    s_next.cnt  = '0;
                    s_next.seen = 1'b1;
                end
            end
            iim_pkg::IIM_ST_RUN: begin
                if (frame_tick) begin
                    // only the frame at the interval boundary is checked
                    check_now   = (s_reg.cnt == '0);
                    s_next.cnt  = (s_reg.cnt + `IIM_CNT_W'(1)) & period_mask(exp_eff);
                    // a packet on the strobe cycle belongs to the new frame: set wins
                    s_next.seen = good_pkt;
                    // no events while the response is not buffer
                    if (check_now && !s_reg.seen
                        && s_reg.response_select == iim_pkg::IIM_RESP_BUF) begin
                        // missing OUT packet raises not-ready at this strobe
                        s_next.not_ready_event  = !s_reg.dir_in;
                        // stale IN data flushed only with flush enabled
                        s_next.flush = s_reg.dir_in && s_reg.iso_in_flush_enable;
                        // double buffering flushes only the earlier side
                        s_next.side  = s_reg.double_buffer_select;
                    end
                end
            end
            default: begin
                s_next.st = iim_pkg::IIM_ST_IDLE;
            end
        endcase
        if (bad_pkt && !good_pkt && s_reg.st == iim_pkg::IIM_ST_RUN) begin
            s_next.seen = s_reg.seen;
        end

        if (wr_stb && adr_i == `IIM_ADR_TIMING) begin
            wv = wb_merge(tim_v, dat_i, sel_i);
            s_next.iso_in_flush_enable = wv[`IIM_TIM_FLUSH];
            // exponent writable only on an iso pipe that has the field
            if (s_reg.iso_type && HAS_INTERVAL) begin
                s_next.interval_exponent = wv[`IIM_TIM_EXP_MSB:`IIM_TIM_EXP_LSB];
            end
        end else if (wr_stb && adr_i == `IIM_ADR_CONTROL) begin
            wv = wb_merge(ctl_v, dat_i, sel_i);
            s_next.response_select = iim_pkg::iim_resp_t'(wv[`IIM_CTL_RESP_MSB:`IIM_CTL_RESP_LSB]);
            s_next.auto_clear_mode = wv[`IIM_CTL_ACLR];
        end else if (wr_stb && adr_i == `IIM_ADR_CONFIG) begin
            wv = wb_merge(cfg_v, dat_i, sel_i);
            s_next.iso_type             = wv[`IIM_CFG_ISO];
            s_next.dir_in               = wv[`IIM_CFG_DIR_IN];
            s_next.double_buffer_select = wv[`IIM_CFG_DBL];
        end

        // leaving buffer response stops the timer so the next start is fresh
        if (s_next.response_select != iim_pkg::IIM_RESP_BUF || !s_next.iso_type) begin
            s_next.st = iim_pkg::IIM_ST_IDLE;
        end
        // auto clear write or bus reset restarts the interval counter
        if (bus_reset_i || (wr_stb && adr_i == `IIM_ADR_CONTROL && wv[`IIM_CTL_ACLR])) begin
            s_next.st   = iim_pkg::IIM_ST_IDLE;
            s_next.cnt  = '0;
            s_next.seen = 1'b0;
        end
    end

    // hardware reset clears the counter and the exponent
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dat_o             = s_reg.rdata;
    assign ack_o             = s_reg.ack;
    assign frame_tick_o      = frame_tick;
    assign not_ready_event_o = s_reg.not_ready_event;
    assign flush_o           = s_reg.flush;
    assign flush_one_side_o  = s_reg.side;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_no_field_exp;
        !HAS_INTERVAL |-> s_reg.interval_exponent == 3'h0;
    endproperty
    a_no_field_exp: assert property (p_no_field_exp) else $error("exponent set on pipe without field");

    property p_exp_locked;
        (wr_stb && adr_i == `IIM_ADR_TIMING && !s_reg.iso_type) |=> $stable(s_reg.interval_exponent);
    endproperty
    a_exp_locked: assert property (p_exp_locked) else $error("exponent written on non-iso pipe");

    property p_not_ready_event_missing;
        (frame_tick && s_reg.st == iim_pkg::IIM_ST_RUN && s_reg.cnt == '0 && !s_reg.seen
         && !s_reg.dir_in && s_reg.response_select == iim_pkg::IIM_RESP_BUF && !bus_reset_i
         && !wr_stb) |=> not_ready_event_o;
    endproperty
    a_not_ready_event_missing: assert property (p_not_ready_event_missing) else $error("missing packet not reported");

    property p_not_ready_event_at_tick;
        not_ready_event_o |-> $past(frame_tick) && !$past(s_reg.seen);
    endproperty
    a_not_ready_event_at_tick: assert property (p_not_ready_event_at_tick) else $error("not-ready outside frame strobe");

    property p_nak_quiet;
        s_reg.response_select != iim_pkg::IIM_RESP_BUF |=> !not_ready_event_o && !flush_o;
    endproperty
    a_nak_quiet: assert property (p_nak_quiet) else $error("event raised under NAK");

    property p_flush_off;
        !s_reg.iso_in_flush_enable |=> !flush_o;
    endproperty
    a_flush_off: assert property (p_flush_off) else $error("flush with flushing disabled");

    property p_flush_side;
        flush_o |-> flush_one_side_o == $past(s_reg.double_buffer_select) && $past(frame_tick);
    endproperty
    a_flush_side: assert property (p_flush_side) else $error("flush side or timing wrong");

    property p_bus_reset;
        bus_reset_i |=> s_reg.st == iim_pkg::IIM_ST_IDLE && s_reg.cnt == '0 ##1 !not_ready_event_o;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset did not clear counter");

    property p_interp;
        (s_reg.tmr == TW'(FRAME_CYCLES - 1) && !sof_i) |-> frame_tick ##1 s_reg.tmr == '0;
    endproperty
    a_interp: assert property (p_interp) else $error("interpolated frame strobe missing");

    property p_sof_restart;
        sof_i |=> s_reg.tmr == '0;
    endproperty
    a_sof_restart: assert property (p_sof_restart) else $error("timer not restarted");

    property p_err_not_seen;
        (s_reg.st == iim_pkg::IIM_ST_RUN && bad_pkt && !good_pkt && !frame_tick
         && !bus_reset_i && !wr_stb) |=> s_reg.seen == $past(s_reg.seen);
    endproperty
    a_err_not_seen: assert property (p_err_not_seen) else $error("bad packet marked");

    property p_good_seen;
        (good_pkt && s_reg.st == iim_pkg::IIM_ST_RUN && !bus_reset_i && !wr_stb) |=> s_reg.seen;
    endproperty
    a_good_seen: assert property (p_good_seen) else $error("good packet not marked");

    property p_start_zero;
        (s_reg.st == iim_pkg::IIM_ST_ARMED && exp_eff == 3'h0 && frame_tick
         && !bus_reset_i && !wr_stb) |=> s_reg.st == iim_pkg::IIM_ST_RUN && s_reg.cnt == '0;
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("no start at next frame");

    property p_start_pkt;
        (s_reg.st == iim_pkg::IIM_ST_ARMED && exp_eff != 3'h0 && good_pkt
         && !bus_reset_i && !wr_stb) |=> s_reg.st == iim_pkg::IIM_ST_RUN && s_reg.seen;
    endproperty
    a_start_pkt: assert property (p_start_pkt) else $error("no start at first packet");

    property p_wait_pkt;
        (s_reg.st == iim_pkg::IIM_ST_ARMED && exp_eff != 3'h0 && !good_pkt)
        |=> s_reg.st != iim_pkg::IIM_ST_RUN;
    endproperty
    a_wait_pkt: assert property (p_wait_pkt) else $error("start without packet");

    property p_cnt_range;
        s_reg.st == iim_pkg::IIM_ST_RUN |-> (s_reg.cnt >> exp_eff) == '0;
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("count beyond interval");

    property p_not_ready_event_boundary;
        not_ready_event_o |-> $past(s_reg.cnt) == '0 && !$past(s_reg.dir_in);
    endproperty
    a_not_ready_event_boundary: assert property (p_not_ready_event_boundary) else $error("check off boundary");

    property p_flush_boundary;
        flush_o |-> $past(s_reg.cnt) == '0 && $past(s_reg.dir_in) && !$past(s_reg.seen);
    endproperty
    a_flush_boundary: assert property (p_flush_boundary) else $error("flush off boundary");

    property p_flush_missing;
        (frame_tick && s_reg.st == iim_pkg::IIM_ST_RUN && s_reg.cnt == '0 && !s_reg.seen
         && s_reg.dir_in && s_reg.iso_in_flush_enable
         && s_reg.response_select == iim_pkg::IIM_RESP_BUF) |=> flush_o;
    endproperty
    a_flush_missing: assert property (p_flush_missing) else $error("stale data not flushed");

    property p_flush_err;
        (s_reg.st == iim_pkg::IIM_ST_RUN && in_token_err_i && !in_token_ok_i && s_reg.dir_in
         && !frame_tick && !bus_reset_i && !wr_stb) |=> s_reg.seen == $past(s_reg.seen);
    endproperty
    a_flush_err: assert property (p_flush_err) else $error("errored token counted");

    property p_idle_quiet;
        s_reg.st != iim_pkg::IIM_ST_RUN |=> !not_ready_event_o && !flush_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("event before counting");

    property p_iso_only;
        !s_reg.iso_type |-> s_reg.st == iim_pkg::IIM_ST_IDLE;
    endproperty
    a_iso_only: assert property (p_iso_only) else $error("timer runs on non-iso pipe");

    property p_busy;
        1'b1 |=> s_reg.pipe_in_use == $past(xact_active_i);
    endproperty
    a_busy: assert property (p_busy) else $error("pipe in use wrong");

    property p_aclr;
        (wr_stb && adr_i == `IIM_ADR_CONTROL && wv[`IIM_CTL_ACLR])
        |=> s_reg.st == iim_pkg::IIM_ST_IDLE && s_reg.cnt == '0;
    endproperty
    a_aclr: assert property (p_aclr) else $error("auto clear did not restart");

    property p_hw_reset_exp;
        $fell(rst_i) |-> s_reg.interval_exponent == `IIM_EXP_RST;
    endproperty
    a_hw_reset_exp: assert property (p_hw_reset_exp) else $error("exponent not cleared");
endmodule
`default_nettype wire

// file: pkg/iim_params.svh
// constants of the isochronous interval monitor: register map, fields, reset values, timing
// assumes inclusion by bare name from the design file
// Functional notes
// - iso IN pipe with flush on: discard buffer if no IN token in checked frame.
// - with double buffering, flush discards only the earlier buffer side.
// - the IN flush happens when the SOF after the checked frame arrives.
// - a corrupted SOF still flushes, at the interpolated SOF time.
// - interval is two to the power of the exponent, in frames.
// - pipes without exponent field have no interval; software writes zero there.
// - the exponent is writable only when the pipe is isochronous.
// - iso OUT pipe raises not-ready when the checked frame lacks its packet.
// - errored packets or a full buffer also raise not-ready.
// - not-ready is signalled at the next SOF or interpolated SOF.
// - nonzero exponent evaluates only at the SOF closing each interval.
// - once running, NAK response suppresses not-ready despite arriving SOFs.
// - exponent zero starts counting in the frame after switching to buffer response.
// - nonzero exponent starts counting at the first good packet under buffer response.
// - iso IN with flush off answers every token; interval is ignored.
// - with flush on, an errored IN token also leads to a flush.
// - IN pipes start counting under the same conditions as OUT pipes.
// - counter restarts on hardware reset, auto clear write and bus reset.
// - exponent sits in bits two to zero of the timing register.
// - flush enable is bit twelve of the timing register.
// - pipe in use reads one while the pipe is in a bus transaction.
`ifndef IIM_PARAMS_SVH
`define IIM_PARAMS_SVH

`define IIM_ADR_TIMING   4'h0
`define IIM_ADR_CONTROL  4'h4
`define IIM_ADR_CONFIG   4'h8
`define IIM_ADR_STATUS   4'hC

`define IIM_TIM_EXP_LSB  0
`define IIM_TIM_EXP_MSB  2
`define IIM_TIM_FLUSH    12
`define IIM_CTL_RESP_LSB 0
`define IIM_CTL_RESP_MSB 1
`define IIM_CTL_BUSY     5
`define IIM_CTL_ACLR     9
`define IIM_CFG_ISO      0
`define IIM_CFG_DIR_IN   1
`define IIM_CFG_DBL      2
`define IIM_STA_CNT_LSB  0
`define IIM_STA_CNT_MSB  6
`define IIM_STA_ST_LSB   8
`define IIM_STA_ST_MSB   9
`define IIM_STA_SEEN     10

`define IIM_EXP_RST      3'h0
`define IIM_CNT_W        7
`define IIM_FRAME_NS     125000
`define IIM_CLK_NS       10

`endif

// file: pkg/iim_pkg.sv
// types shared by the isochronous interval monitor
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package iim_pkg;
    typedef enum logic [1:0] {
        IIM_ST_IDLE  = 2'h0,
        IIM_ST_ARMED = 2'h1,
        IIM_ST_RUN   = 2'h2
    } iim_state_t;

    typedef enum logic [1:0] {
        IIM_RESP_NAK    = 2'h0,
        IIM_RESP_BUF    = 2'h1,
        IIM_RESP_STALL  = 2'h2,
        IIM_RESP_STALL2 = 2'h3
    } iim_resp_t;
endpackage
`default_nettype wire

// file: verification/iim_host_model.sv
// usb host stand-in: sof pulses and at most one packet event per frame
// assumes the bench changes mode and drop between packets
`timescale 1ns/1ps
`default_nettype none
module iim_host_model #(
    parameter int PERIOD = 45
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // scenario control
    input  wire logic       drop_i,
    input  wire logic [2:0] mode_i,
    // link events
    output logic            sof_o,
    output logic [4:0]      evt_o,
    output logic            busy_o
);
    int cnt;

    // period kept below the interpolation span so only dropped sofs get replaced
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            cnt <= 0;
        else
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end

    assign sof_o  = (cnt == PERIOD - 1) && !rst_i && !drop_i;
    // mode 1..5: in ok, in error, out ok, out error, fifo full
    assign evt_o  = (cnt == 10 && mode_i != 3'h0) ? 5'h01 << (mode_i - 3'h1) : 5'h00;
    assign busy_o = (cnt >= 9) && (cnt <= 11);
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the interval monitor
// assumes the host model drives link events; software is the wishbone tasks
`timescale 1ns/1ps
`default_nettype none
`include "iim_params.svh"
module tb;
    localparam int FC = 50;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic        bus_rst = 1'b0;
    logic        drop = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic [31:0] rdat;
    logic        ack, sof, busy, tick, nr, fl, one;
    logic [4:0]  evt;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          checks = 0;
    int          n_nr = 0;
    int          n_fl = 0;
    int          n_one = 0;
    int          ncyc = 0;

    iim_host_model host (.clk_i(clk_i), .rst_i(rst_i), .drop_i(drop), .mode_i(mode),
        .sof_o(sof), .evt_o(evt), .busy_o(busy));

    iim_monitor #(.HAS_INTERVAL(1'b1), .FRAME_CYCLES(FC)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .sof_i(sof), .bus_reset_i(bus_rst), .in_token_ok_i(evt[0]),
        .in_token_err_i(evt[1]), .out_data_ok_i(evt[2]), .out_data_err_i(evt[3]),
        .out_fifo_full_i(evt[4]), .xact_active_i(busy), .frame_tick_o(tick),
        .not_ready_event_o(nr), .flush_o(fl), .flush_one_side_o(one));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (nr === 1'b1) n_nr++;
        if (fl === 1'b1) n_fl++;
        if ((fl & one) === 1'b1) n_one++;
        ncyc++;
        if (ncyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // request held until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        req <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    task automatic wait_tick();
        do @(posedge clk_i); while (tick !== 1'b1);
    endtask

    // counts events caused by k frame strobes after one settling strobe
    task automatic frames(input int k, input int e_nr, input int e_fl);
        int b_nr, b_fl, b_one;
        wait_tick();
        repeat (3) @(posedge clk_i);
        b_nr  = n_nr;
        b_fl  = n_fl;
        b_one = n_one;
        repeat (k) wait_tick();
        repeat (3) @(posedge clk_i);
        chk(32'(n_nr - b_nr), 32'(e_nr));
        chk(32'(n_fl - b_fl), 32'(e_fl));
        chk(32'(n_one - b_one), 32'(e_fl));
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`IIM_ADR_TIMING, 32'hFFFF_FFFF, 32'h0);
        rd(4'h2, 32'hFFFF_FFFF, 32'h0);
        wr(`IIM_ADR_TIMING, 32'h0000_0003);
        rd(`IIM_ADR_TIMING, 32'h7, 32'h0);
        wr(`IIM_ADR_CONFIG, 32'h1);
        wr(`IIM_ADR_TIMING, 32'hFFFF_FFFA);
        rd(`IIM_ADR_TIMING, 32'hFFFF_FFFF, 32'h0000_1002);
        wr(`IIM_ADR_TIMING, 32'h0);
        wr(`IIM_ADR_CONTROL, 32'h1);
        // none, ok, error, fifo full
        for (int m = 0; m < 4; m++) begin
            mode <= (m == 0) ? 3'h0 : 3'(m + 2);
            frames(3, (m == 1) ? 0 : 3, 0);
        end
        mode <= 3'h0;
        wr(`IIM_ADR_CONTROL, 32'h0);
        frames(3, 0, 0);
        wr(`IIM_ADR_CONTROL, 32'h1);
        drop <= 1'b1;
        frames(3, 3, 0);
        drop <= 1'b0;
        wr(`IIM_ADR_CONTROL, 32'h0);
        do wb(1'b0, `IIM_ADR_CONTROL, 32'h0, q); while (q[5] !== 1'b0);
        wr(`IIM_ADR_TIMING, 32'h2);
        wr(`IIM_ADR_CONTROL, 32'h200);
        rd(`IIM_ADR_STATUS, 32'h7F, 32'h0);
        wr(`IIM_ADR_CONTROL, 32'h1);
        frames(8, 0, 0);
        mode <= 3'h3;
        wait_tick();
        mode <= 3'h0;
        frames(8, 2, 0);
        @(posedge clk_i);
        bus_rst <= 1'b1;
        @(posedge clk_i);
        bus_rst <= 1'b0;
        rd(`IIM_ADR_STATUS, 32'h7F, 32'h0);
        wr(`IIM_ADR_CONTROL, 32'h0);
        wr(`IIM_ADR_CONFIG, 32'h7);
        wr(`IIM_ADR_TIMING, 32'h1000);
        wr(`IIM_ADR_CONTROL, 32'h1);
        // no token, good token, errored token
        for (int m = 0; m < 3; m++) begin
            mode <= 3'(m);
            frames(3, 0, (m == 1) ? 0 : 3);
        end
        mode <= 3'h0;
        wr(`IIM_ADR_CONTROL, 32'h0);
        wr(`IIM_ADR_TIMING, 32'h0);
        wr(`IIM_ADR_CONTROL, 32'h1);
        frames(3, 0, 0);
        stop_test();
    end
endmodule
`default_nettype wire
